/* File: hw/eeprom_pkg.sv */
// shared constants and carrier types for the two-wire eeprom target
// assumes a 25 MHz system clock and a link clock that arrives on a pin
package eeprom_pkg;

    // array organisation
    localparam int MEM_BYTES = 8192;
    localparam int ADDR_W = 13;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam int SER_BYTES = 16;
    localparam int SER_W = 4;

    // self-timed write cycle, longest time so the count rounds down
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 17;

    // control byte: type code in [7:5], bit 4 picks array or serial
    localparam logic [2:0] TYPE_CODE = 3'h5;
    localparam int SERIAL_BIT = 4;

    // bit slots within one nine-bit byte frame
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } phase_t;

    // one received byte; first marks the control byte after a start
    typedef struct packed {
        logic [7:0] data;
        logic first;
    } rx_byte_t;

    // rising-edge side of the link
    typedef struct packed {
        logic [7:0] rx;
        logic tgl;
    } link_rx_t;

    // falling-edge side of the link
    typedef struct packed {
        logic oe;
        logic level;
    } link_tx_t;

    // system-clock side state
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic [2:0] sel_s1;
        logic [2:0] sel_s2;
        logic wp_s1;
        logic wp_s2;
        phase_t phase;
        logic [3:0] bitcnt;
        logic drive;
        logic serial_sel;
        logic [ADDR_W-1:0] addr;
        logic [SER_W-1:0] ser_addr;
        logic [7:0] out_byte;
        logic wdata_seen;
        logic [PAGE_BYTES-1:0][7:0] page_data;
        logic [PAGE_BYTES-1:0] page_mask;
        logic busy;
        logic [TIMER_W-1:0] timer;
    } core_t;

endpackage

/* File: hw/byte_fifo.sv */
// small valid/ready buffer between the link receiver and the byte handler
// assumes one clock domain; depth a power of two, at least two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("byte_fifo depth must be a power of two, at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } fifo_t;

    fifo_t q;
    fifo_t d;
    logic push;
    logic pop;

    // flags straight from the count, so full and empty never lie
    assign in_ready_o = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o = q.slot[q.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointers wrap naturally since depth is a power of two
    always_comb begin
        d = q;
        if (push) begin
            d.slot[q.wr] = in_data_i;
            d.wr = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: d.cnt = q.cnt + 1'b1;
            2'b01: d.cnt = q.cnt - 1'b1;
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

/* File: hw/eeprom_target.sv */
// two-wire serial eeprom target: link front end, byte handler, array
// assumes scl_i is the controller's clock and idles high between frames,
// and that an external pull-up makes a released data line read high
//
// Operation
// RQ1: command and write bits are sampled on each rising link clock edge.
// RQ2: read data changes after each falling link edge, stable while high.
// RQ3: controller keeps the link clock high, or floating high, when idle.
// RQ4: data line is only pulled low or released; pull-up makes it high.
// RQ5: respond only when address select bits equal the three select pins.
// RQ6: undriven select and write-protect pins count as low; no pull-down here, reset only clears their syncs.
// RQ7: write-protect high blocks all array writes; low lets them happen.
// RQ8: array holds 8192 bytes addressed by 13 bits.
// RQ9: page writes up to 32 bytes, partial pages allowed.
// RQ10: self-timed programming finishes within 5 ms without link clocking.
// RQ11: 128-bit serial number, readable, never writable.
// RQ12: random reads at a chosen address and sequential reads.
// RQ13: link works at 100 kHz, 400 kHz and 1 MHz clock rates.
// RQ14: on select mismatch keep data released and ignore until next start.
`timescale 1ns/1ps
`default_nettype none
module eeprom_target #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
    // arbitrary value, stands in for the factory serial number
    parameter logic [127:0] SERIAL_NUM = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
    // system clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // two-wire link, data line as open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // strap pins
    input wire logic select_pin_bit0_i,
    input wire logic select_pin_bit1_i,
    input wire logic select_pin_bit2_i,
    input wire logic write_protect_i,
    // status
    output logic write_busy_o
);
    localparam int PAGE_BYTES = eeprom_pkg::PAGE_BYTES;
    localparam int TIMER_W = eeprom_pkg::TIMER_W;
    localparam int ADDR_W = eeprom_pkg::ADDR_W;
    localparam int PAGE_W = eeprom_pkg::PAGE_W;
    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] COMMIT_END = TIMER_W'(PAGE_BYTES);
    localparam int RX_W = $bits(eeprom_pkg::rx_byte_t);

    if (WRITE_CYCLES <= PAGE_BYTES || WRITE_CYCLES >= (1 << TIMER_W))
    begin : g_bad_cycles
        $error("write cycle count out of range for the timer");
    end

    eeprom_pkg::core_t q;
    eeprom_pkg::core_t d;
    eeprom_pkg::link_rx_t lk_q;
    eeprom_pkg::link_tx_t tx_q;
    logic [7:0] mem [eeprom_pkg::MEM_BYTES];

    logic start;
    logic stop;
    logic bit_ev;
    logic push;
    logic pop;
    logic in_ready;
    logic out_valid;
    logic hdl_ready;
    logic match;
    logic commit;
    logic [RX_W-1:0] in_bits;
    logic [RX_W-1:0] out_bits;
    eeprom_pkg::rx_byte_t ent;
    eeprom_pkg::rx_byte_t in_ent;
    logic [7:0] rd_byte;

    // link side, rising edge: shift in one bit, toggle marks its arrival
    always_ff @(posedge scl_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_q <= '0;
        end else begin
            lk_q.rx <= {lk_q.rx[6:0], sda_i}; // RQ1
            lk_q.tgl <= ~lk_q.tgl;
        end
    end

    // link side, falling edge: the core answers each rising-edge toggle
    // well before the next fall, so drive is settled when it is taken here
    always_ff @(negedge scl_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_q <= '0;
        end else begin
            tx_q.oe <= q.drive; // RQ2
            tx_q.level <= 1'b0; // RQ4
        end
    end

    assign sda_oe_o = tx_q.oe;
    assign sda_o = tx_q.level;
    assign write_busy_o = q.busy;

    // start and stop seen as data edges while the synced clock stays high
    assign start = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
    assign stop = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;
    // three clocks from rise to event keeps fast-mode plus high phases safe
    assign bit_ev = q.tgl_s2 ^ q.tgl_s3; // RQ13

    // a byte is refused while the buffer is full, so never half-taken
    assign push = bit_ev && !start && !stop && in_ready &&
        q.bitcnt == eeprom_pkg::LAST_DATA_BIT &&
        q.phase inside {eeprom_pkg::ST_DEV, eeprom_pkg::ST_ADDR_HI,
            eeprom_pkg::ST_ADDR_LO, eeprom_pkg::ST_WDATA};
    assign in_ent.data = lk_q.rx;
    assign in_ent.first = (q.phase == eeprom_pkg::ST_DEV);
    assign in_bits = in_ent;
    assign ent = eeprom_pkg::rx_byte_t'(out_bits);

    // handler stalls while the page buffer is being programmed
    assign commit = q.busy && q.timer < COMMIT_END;
    assign hdl_ready = !commit;
    assign pop = out_valid && hdl_ready;

    assign match = ent.data[7:5] == eeprom_pkg::TYPE_CODE &&
        ent.data[3:1] == q.sel_s2 && !q.busy; // RQ5

    // byte source for reads: array or the fixed serial number
    always_comb begin
        if (q.serial_sel) begin
            rd_byte = SERIAL_NUM[{q.ser_addr, 3'h0} +: 8]; // RQ11
        end else begin
            rd_byte = mem[q.addr]; // RQ8
        end
    end

    byte_fifo #(
        .WIDTH(RX_W),
        .DEPTH(2)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(push),
        .in_data_i(in_bits),
        .in_ready_o(in_ready),
        .out_valid_o(out_valid),
        .out_data_o(out_bits),
        .out_ready_i(hdl_ready)
    );

    // core next state: synchronisers, bit framing, byte handler, timer
    always_comb begin
        d = q;
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        d.tgl_s1 = lk_q.tgl;
        d.tgl_s2 = q.tgl_s1;
        d.tgl_s3 = q.tgl_s2;
        d.sel_s1 = {select_pin_bit2_i, select_pin_bit1_i, select_pin_bit0_i};
        d.sel_s2 = q.sel_s1;
        d.wp_s1 = write_protect_i;
        d.wp_s2 = q.wp_s1;
        if (start) begin
            d.phase = eeprom_pkg::ST_DEV;
            d.bitcnt = '0;
            d.drive = 1'b0;
            d.wdata_seen = 1'b0;
            if (!q.busy) begin
                d.page_mask = '0;
            end
        end else if (stop) begin
            d.phase = eeprom_pkg::ST_IDLE;
            d.drive = 1'b0;
            d.wdata_seen = 1'b0;
            if (q.wdata_seen && !q.wp_s2 && !q.busy) begin // RQ7
                d.busy = 1'b1;
                d.timer = '0;
            end
        end else if (bit_ev && q.phase != eeprom_pkg::ST_IDLE) begin
            if (q.bitcnt == eeprom_pkg::ACK_SLOT) begin
                d.bitcnt = '0;
            end else begin
                d.bitcnt = q.bitcnt + 4'h1;
            end
            case (q.phase)
                eeprom_pkg::ST_IGNORE: begin
                    d.drive = 1'b0; // RQ14
                end
                eeprom_pkg::ST_RDATA: begin
                    // our own ack after the control byte also reads as low
                    if (q.bitcnt == eeprom_pkg::ACK_SLOT) begin
                        if (!lk_q.rx[0]) begin
                            d.out_byte = rd_byte;
                            d.drive = ~rd_byte[7]; // RQ2
                            d.addr = q.addr + 13'h1; // RQ12
                            d.ser_addr = q.ser_addr + 4'h1;
                        end else begin
                            d.phase = eeprom_pkg::ST_IGNORE;
                            d.drive = 1'b0;
                        end
                    end else if (q.bitcnt == eeprom_pkg::LAST_DATA_BIT) begin
                        d.drive = 1'b0;
                    end else begin
                        d.out_byte = {q.out_byte[6:0], 1'b0};
                        d.drive = ~q.out_byte[6]; // RQ4
                    end
                end
                default: begin
                    if (q.bitcnt == eeprom_pkg::ACK_SLOT) begin
                        d.drive = 1'b0;
                    end else if (q.bitcnt == eeprom_pkg::LAST_DATA_BIT &&
                        !in_ready) begin
                        d.phase = eeprom_pkg::ST_IGNORE;
                    end
                end
            endcase
        end
        // handler: one byte from the buffer, ack decided before the fall
        if (pop) begin
            if (ent.first) begin
                if (match) begin
                    d.drive = 1'b1;
                    d.serial_sel = ent.data[eeprom_pkg::SERIAL_BIT];
                    if (ent.data[0]) begin
                        d.phase = eeprom_pkg::ST_RDATA; // RQ12
                    end else begin
                        d.phase = eeprom_pkg::ST_ADDR_HI;
                    end
                end else begin
                    d.phase = eeprom_pkg::ST_IGNORE; // RQ14
                    d.drive = 1'b0;
                end
            end else begin
                case (q.phase)
                    eeprom_pkg::ST_ADDR_HI: begin
                        d.addr[ADDR_W-1:8] = ent.data[ADDR_W-9:0]; // RQ8
                        d.drive = 1'b1;
                        d.phase = eeprom_pkg::ST_ADDR_LO;
                    end
                    eeprom_pkg::ST_ADDR_LO: begin
                        d.addr[7:0] = ent.data;
                        d.ser_addr = ent.data[eeprom_pkg::SER_W-1:0];
                        d.drive = 1'b1;
                        d.phase = eeprom_pkg::ST_WDATA;
                    end
                    eeprom_pkg::ST_WDATA: begin
                        if (q.serial_sel) begin
                            d.drive = 1'b0; // RQ11
                            d.phase = eeprom_pkg::ST_IGNORE;
                        end else begin
                            // offset wraps inside the page
                            d.page_data[q.addr[PAGE_W-1:0]] = ent.data;
                            d.page_mask[q.addr[PAGE_W-1:0]] = 1'b1;
                            d.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] +
                                5'h1; // RQ9
                            d.wdata_seen = 1'b1;
                            d.drive = 1'b1;
                        end
                    end
                    default: begin
                        d.drive = 1'b0;
                    end
                endcase
            end
        end
        // self-timed cycle runs on the system clock, not the link
        if (q.busy) begin
            d.timer = q.timer + 17'h1;
            if (q.timer == TIMER_LAST) begin
                d.busy = 1'b0; // RQ10
                d.page_mask = '0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0; // RQ6
        end else begin
            q <= d;
        end
    end

    // array programming, one page slot per cycle at the start of the cycle
    always_ff @(posedge clk_i) begin
        if (commit && q.page_mask[q.timer[PAGE_W-1:0]]) begin
            mem[{q.addr[ADDR_W-1:PAGE_W], q.timer[PAGE_W-1:0]}] <=
                q.page_data[q.timer[PAGE_W-1:0]]; // RQ9
        end
    end

    rx_sample_a: assert property ( // RQ1
        @(posedge scl_i) disable iff (!nrst_i)
        1'b1 |=> lk_q.rx[0] == $past(sda_i) &&
            lk_q.rx[7:1] == $past(lk_q.rx[6:0])
    ) else $error("link bit not taken on rising edge");

    open_drain_a: assert property ( // RQ4
        @(posedge clk_i) disable iff (!nrst_i)
        sda_oe_o |-> sda_o == 1'b0
    ) else $error("data line driven high");

    // the enable only moves on a falling link edge, so never while high
    drive_stable_a: assert property ( // RQ2
        @(posedge clk_i) disable iff (!nrst_i)
        scl_i |-> $stable(sda_oe_o)
    ) else $error("data output moved while link clock high");

    select_miss_a: assert property ( // RQ5
        @(posedge clk_i) disable iff (!nrst_i)
        pop && ent.first && ent.data[3:1] != q.sel_s2
        |=> q.phase == eeprom_pkg::ST_IGNORE && !q.drive
    ) else $error("answered with wrong select bits");

    ignore_hold_a: assert property ( // RQ14
        @(posedge clk_i) disable iff (!nrst_i)
        q.phase == eeprom_pkg::ST_IGNORE && !start && !stop
        |=> q.phase == eeprom_pkg::ST_IGNORE && !q.drive
    ) else $error("left ignore state without a start");

    protect_block_a: assert property ( // RQ7
        @(posedge clk_i) disable iff (!nrst_i)
        stop && q.wp_s2 && !q.busy |=> !q.busy [*2]
    ) else $error("write started while protected");

    write_start_a: assert property ( // RQ7
        @(posedge clk_i) disable iff (!nrst_i)
        stop && q.wdata_seen && !q.wp_s2 && !q.busy
        |=> q.busy && q.timer == '0
    ) else $error("write cycle not started after stop");

    write_end_a: assert property ( // RQ10
        @(posedge clk_i) disable iff (!nrst_i)
        q.busy |-> q.timer <= TIMER_LAST ##1
            ($past(q.timer) == TIMER_LAST) == !q.busy
    ) else $error("write cycle length wrong");

    serial_ro_a: assert property ( // RQ11
        @(posedge clk_i) disable iff (!nrst_i)
        pop && !ent.first && q.phase == eeprom_pkg::ST_WDATA && q.serial_sel
        |=> !q.drive && q.page_mask == $past(q.page_mask)
    ) else $error("serial number accepted a write");

    page_wrap_a: assert property ( // RQ9
        @(posedge clk_i) disable iff (!nrst_i)
        pop && !ent.first && q.phase == eeprom_pkg::ST_WDATA && !q.serial_sel
        |=> q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W]) &&
            q.drive
    ) else $error("page write left its page");

    seq_read_a: assert property ( // RQ12
        @(posedge clk_i) disable iff (!nrst_i)
        bit_ev && !start && !stop && q.phase == eeprom_pkg::ST_RDATA &&
        q.bitcnt == eeprom_pkg::ACK_SLOT && !lk_q.rx[0]
        |=> q.addr == $past(q.addr) + 13'h1 && q.drive == !q.out_byte[7]
    ) else $error("sequential read did not advance");

endmodule
`default_nettype wire

/* File: tb/link_ctrl_model.sv */
// behavioural two-wire bus controller that clocks the eeprom target
// assumes the bench resolves the data line with a pull-up outside
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_model #(
    // slot unit; one bit takes seven units, about 893 kHz
    parameter int TICK_NS = 160
) (
    // link clock and open-drain pull, high pulls the line low
    output logic scl_o,
    output logic pull_o,
    // resolved line level
    input wire logic sda_i
);
    // idle bus: clock stands high, line released
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end

    // one bit slot; data only moves while the clock is low
    task automatic bit_slot(input logic b, output logic s);
        #(2*TICK_NS) pull_o = !b;
        #(2*TICK_NS) scl_o = 1'b1;
        #(2*TICK_NS) s = sda_i;
        #(TICK_NS) scl_o = 1'b0;
    endtask

    // start or repeated start: line falls while the clock is high
    task automatic start_cond();
        #(2*TICK_NS) pull_o = 1'b0;
        #(2*TICK_NS) scl_o = 1'b1;
        #(2*TICK_NS) pull_o = 1'b1;
        #(2*TICK_NS) scl_o = 1'b0;
    endtask

    // stop, then a bus-free gap with the clock parked high
    task automatic stop_cond();
        #(2*TICK_NS) pull_o = 1'b1;
        #(2*TICK_NS) scl_o = 1'b1;
        #(2*TICK_NS) pull_o = 1'b0;
        #(4*TICK_NS);
    endtask

    // byte out, msb first, then the target's answer in slot nine
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], s);
        end
        bit_slot(1'b1, s);
        ack = !s;
    endtask

    // byte in; more low sends the final not-acknowledge
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            d[i] = s;
        end
        bit_slot(!more, s);
    endtask
endmodule
`default_nettype wire

/* File: tb/two_wire_eeprom_pin_interface_tb_top.sv */
// self-checking bench for the eeprom target against a queue-free model
// assumes link_ctrl_model as controller and a pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
module two_wire_eeprom_pin_interface_tb_top;
    // long enough that an acknowledge poll lands inside the write cycle
    localparam int WCYC = 2000;
    // arbitrary value, stands in for the factory serial number
    localparam logic [127:0] SER = 128'h8899aabbccddeeff0011223344556677;
    logic clk_i;
    logic nrst_i;
    logic scl;
    logic pull;
    logic sda;
    logic sda_o;
    logic sda_oe_o;
    logic busy;
    logic [2:0] sel;
    logic wp;
    logic [12:0] a;
    int errors = 0;
    int compares = 0;
    int busy_len = 0;
    int last_len = 0;
    logic [7:0] mem [int];

    // wired-and line with pull-up
    assign sda = (pull || (sda_oe_o && !sda_o)) ? 1'b0 : 1'b1;

    eeprom_target #(.WRITE_CYCLES(WCYC), .SERIAL_NUM(SER)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_pin_bit0_i(sel[0]),
        .select_pin_bit1_i(sel[1]), .select_pin_bit2_i(sel[2]),
        .write_protect_i(wp), .write_busy_o(busy));
    link_ctrl_model ctrl (.scl_o(scl), .pull_o(pull), .sda_i(sda));

    // 25 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // length of each busy window in system clocks
    always @(posedge clk_i) begin
        if (busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            last_len <= busy_len;
            busy_len <= 0;
        end
    end

    // output may only move with the clock low, and only ever pulls low
    always @(sda_oe_o or sda_o) begin
        if (nrst_i === 1'b1 &&
            (scl === 1'b1 || sda_o !== 1'b0)) begin
            errors++;
            $display("ERROR %0t data output moved badly", $time);
        end
    end

    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] cbyte(input logic ser, input logic [2:0] s,
                                         input logic rd);
        return {eeprom_pkg::TYPE_CODE, ser, s, rd};
    endfunction

    // straps move off the sampling edge, then settle through the syncs
    task automatic set_straps(input logic [2:0] s, input logic w);
        @(negedge clk_i);
        sel = s;
        wp = w;
        repeat (4) @(negedge clk_i);
    endtask

    task automatic addr_frame(input logic ser, input logic [12:0] ad);
        logic ack;
        ctrl.start_cond();
        ctrl.send_byte(cbyte(ser, sel, 1'b0), ack);
        check({7'h00, ack}, 8'h01, "control ack");
        ctrl.send_byte({3'h0, ad[12:8]}, ack);
        check({7'h00, ack}, 8'h01, "high address ack");
        ctrl.send_byte(ad[7:0], ack);
        check({7'h00, ack}, 8'h01, "low address ack");
    endtask

    // foreign select: silence now and for the rest of the frame
    task automatic wrong_select();
        logic ack;
        ctrl.start_cond();
        ctrl.send_byte(cbyte(1'b0, sel ^ 3'(1 + $urandom_range(6)), 1'b0),
                       ack);
        check({7'h00, ack}, 8'h00, "foreign select");
        ctrl.send_byte(8'(~sel), ack);
        check({7'h00, ack}, 8'h00, "ignored byte");
        ctrl.stop_cond();
    endtask

    task automatic write_page(input logic ser, input logic [12:0] ad,
                              input int n);
        logic ack;
        logic [7:0] d;
        addr_frame(ser, ad);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            ctrl.send_byte(d, ack);
            check({7'h00, ack}, {7'h00, !ser}, "data ack");
            if (!ser && !wp) mem[{ad[12:5], 5'(ad[4:0] + k)}] = d;
        end
        ctrl.stop_cond();
        if (n > 0 && !ser && !wp) begin
            check({7'h00, busy}, 8'h01, "write cycle started");
            ctrl.start_cond();
            ctrl.send_byte(cbyte(1'b0, sel, 1'b0), ack);
            check({7'h00, ack}, 8'h00, "poll while busy");
            ctrl.stop_cond();
            for (int i = 0; i <= WCYC && busy !== 1'b0; i++) begin
                @(negedge clk_i);
            end
            // a cycle that never ends is a mismatch and ends the run
            if (busy !== 1'b0) begin
                errors++;
                $display("ERROR %0t write cycle never ended", $time);
                end_sim();
            end
            @(negedge clk_i);
            check({7'h00, busy}, 8'h00, "write cycle ended");
            check(8'(last_len == WCYC), 8'h01, "write cycle length");
        end else begin
            repeat (16) @(negedge clk_i);
            check({7'h00, busy}, 8'h00, "no write cycle");
        end
    endtask

    task automatic read_seq(input logic ser, input logic [12:0] ad,
                            input int n);
        logic ack;
        logic [7:0] d;
        addr_frame(ser, ad);
        ctrl.start_cond();
        ctrl.send_byte(cbyte(ser, sel, 1'b1), ack);
        check({7'h00, ack}, 8'h01, "read control ack");
        for (int k = 0; k < n; k++) begin
            ctrl.recv_byte(k < n - 1, d);
            if (ser) begin
                check(d, SER[8*((ad[3:0] + k) % 16) +: 8], "serial");
            end else begin
                check(d, mem[13'(ad + k)], "array byte");
            end
        end
        ctrl.stop_cond();
    endtask

    // watchdog against a hung frame
    initial begin
        #(40 * 100000);
        errors++;
        $display("ERROR %0t run did not finish", $time);
        end_sim();
    end

    initial begin
        nrst_i = 1'b0;
        sel = 3'h0;
        wp = 1'b0;
        a = 13'h0000;
        void'($urandom(60));
        repeat (4) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        check({6'h00, sda_oe_o, busy}, 8'h00, "reset outputs");
        // every select strap value with write protect low, with a foreign select and a dataless frame
        for (int s = 0; s < 8; s++) begin
            set_straps(3'(s), 1'b0);
            wrong_select();
            write_page(1'b0, 13'(s), 0);
        end
        set_straps(3'($urandom), 1'b0);
        write_page(1'b0, 13'h0000, 2);
        write_page(1'b0, 13'h1fe0, 32);
        a = {8'($urandom_range(254, 1)), 5'h1c};
        write_page(1'b0, a, 8);
        read_seq(1'b0, 13'h1ffe, 4);
        read_seq(1'b0, a, 4);
        read_seq(1'b0, {a[12:5], 5'h00}, 4);
        set_straps(sel, 1'b1);
        write_page(1'b0, 13'h1fe0, 4);
        read_seq(1'b0, 13'h1fe0, 4);
        set_straps(sel, 1'b0);
        write_page(1'b1, 13'($urandom), 1);
        read_seq(1'b1, 13'($urandom), 16);
        end_sim();
    end
endmodule
`default_nettype wire
